// *** src/relay_diag_pkg.sv ***
package relay_diag_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ             = 100;
  localparam int OPEN_LOAD_MIN_US    = 30;
  localparam int OPEN_LOAD_MAX_US    = 200;
  localparam int OVERLOAD_MIN_US     = 3;
  localparam int OVERLOAD_MAX_US     = 50;
  // Least times round up; the qualifying count sits at the minimum.
  localparam int OPEN_LOAD_CYCLES    = OPEN_LOAD_MIN_US * CLK_MHZ;
  localparam int OVERLOAD_CYCLES     = OVERLOAD_MIN_US * CLK_MHZ;
  localparam int DELAY_W             = 15;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int CHANNELS            = 8;
  localparam int WORD_W              = 16;
  localparam int COUNT_W             = 8;
  localparam int MIN_BITS            = 16;
  localparam int BYTE_MASK           = 7;
  localparam logic [15:0] CMD_RESET  = 16'hFFFF;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_INPUT   = 2'h1,
    MODE_ON      = 2'h2,
    MODE_OFF     = 2'h3
  } mode_t;

  // Serial pins after synchronisation.
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } serial_in_t;

  // Fault indications of one channel.
  typedef struct packed {
    logic overtemp;
    logic overload;
    logic open_load;
  } fault_in_t;

endpackage

// *** src/pin_sync.sv ***
`timescale 1ns/100ps
module pin_sync (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire relay_diag_pkg::serial_in_t raw,
  output relay_diag_pkg::serial_in_t    synced
);

  // ---------------------------------------------------------------
  // Two stages; the first is read only by the second.
  // ---------------------------------------------------------------
  typedef struct packed {
    relay_diag_pkg::serial_in_t meta;
    relay_diag_pkg::serial_in_t sync;
  } state_t;

  state_t state;
  state_t next_state;

  always_comb begin
    next_state      = state;
    next_state.meta = raw;
    next_state.sync = state.meta;
    if (srst) begin
      next_state = '{meta: 3'h2, sync: 3'h2};
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign synced = state.sync;

endmodule

// *** src/channel_diag.sv ***
`timescale 1ns/100ps
module channel_diag (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic [1:0]              mode,
  input  wire logic                    in_pin,
  input  wire relay_diag_pkg::fault_in_t fault,
  output logic                         drive_on,
  output logic                         fault_flag,
  output logic                         open_load_flag
);

  typedef struct packed {
    logic                                    fault_flag;
    logic                                    open_load_flag;
    logic [relay_diag_pkg::DELAY_W-1:0]      ol_count;
    logic [relay_diag_pkg::DELAY_W-1:0]      ovl_count;
  } state_t;

  state_t state;
  state_t next_state;
  logic   want_on;
  logic   standby;

  always_comb begin
    standby = (mode == relay_diag_pkg::MODE_STANDBY);
    want_on = (mode == relay_diag_pkg::MODE_ON) || (mode == relay_diag_pkg::MODE_INPUT && in_pin);
  end

  // ---------------------------------------------------------------
  // Flags and delay counters
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (standby) begin
      next_state = '0;
    end else begin
      if (fault.overtemp && want_on) begin
        next_state.fault_flag = 1'b1;
      end
      if (drive_on && fault.overload) begin
        if (state.ovl_count == relay_diag_pkg::DELAY_W'(relay_diag_pkg::OVERLOAD_CYCLES - 1)) begin
          next_state.fault_flag = 1'b1;
        end else begin
          next_state.ovl_count = state.ovl_count + 1'b1;
        end
      end else begin
        next_state.ovl_count = '0;
      end
      if (!want_on && fault.open_load) begin
        if (state.ol_count == relay_diag_pkg::DELAY_W'(relay_diag_pkg::OPEN_LOAD_CYCLES - 1)) begin
          next_state.open_load_flag = 1'b1;
        end else begin
          next_state.ol_count = state.ol_count + 1'b1;
        end
      end else begin
        next_state.ol_count = '0;
      end
    end
    if (srst) begin
      next_state = '0;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  // A latched fault keeps the stage off until standby clears it.
  assign drive_on       = want_on && !state.fault_flag && !fault.overtemp;
  assign fault_flag     = state.fault_flag;
  assign open_load_flag = state.open_load_flag;

  // Without overtemperature, the flag may only rise once the full overload delay has run.
  chk_overload_delay: assert property (@(posedge clk) disable iff (srst)
    $rose(state.fault_flag) && !$past(fault.overtemp)
      |-> $past(state.ovl_count) == relay_diag_pkg::DELAY_W'(relay_diag_pkg::OVERLOAD_CYCLES - 1))
    else $error("fault flag set before overload delay");
  chk_standby_clears: assert property (@(posedge clk) disable iff (srst)
    standby |=> !state.fault_flag && !state.open_load_flag)
    else $error("standby did not clear flags");
  chk_ol_on_blocked: assert property (@(posedge clk) disable iff (srst)
    want_on |=> state.ol_count == '0)
    else $error("open load timing ran while on");

endmodule

// *** src/relay_switch_spi_diagnosis.sv ***
`timescale 1ns/100ps
module relay_switch_spi_diagnosis (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      sclk,
  input  wire logic                      cs_n,
  input  wire logic                      mosi,
  output logic                           miso_out,
  output logic                           miso_oe,
  input  wire logic [7:0]                in_pins,
  input  wire relay_diag_pkg::fault_in_t faults [8],
  output logic [7:0]                     channel_on,
  output logic [15:0]                    command_word,
  output logic                           transfer_error_flag
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic count_valid(input logic [relay_diag_pkg::COUNT_W-1:0] n);
    count_valid = (n >= relay_diag_pkg::COUNT_W'(relay_diag_pkg::MIN_BITS))
               && ((n & relay_diag_pkg::COUNT_W'(relay_diag_pkg::BYTE_MASK)) == '0);
  endfunction

  typedef struct packed {
    logic [15:0]                         command;
    logic [15:0]                         rx_shift;
    logic [15:0]                         tx_shift;
    logic [relay_diag_pkg::COUNT_W-1:0]  bit_count;
    logic                                error_flag;
    logic                                active;
    logic                                first_rise_seen;
    logic                                sclk_d;
    logic                                cs_n_d;
    logic                                miso;
  } state_t;

  state_t                     state;
  state_t                     next_state;
  relay_diag_pkg::serial_in_t raw;
  relay_diag_pkg::serial_in_t pins;
  logic [7:0]                 fault_flags;
  logic [7:0]                 open_flags;
  logic [15:0]                diag_word;
  logic                       sclk_rise;
  logic                       sclk_fall;
  logic                       cs_fall;
  logic                       cs_rise;

  assign raw = '{sclk: sclk, cs_n: cs_n, mosi: mosi};

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  pin_sync u_sync (
    .clk    (clk),
    .srst   (srst),
    .raw    (raw),
    .synced (pins)
  );

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  for (genvar i = 0; i < relay_diag_pkg::CHANNELS; i++) begin : g_ch
    channel_diag u_ch (
      .clk            (clk),
      .srst           (srst),
      .mode           (state.command[2*i +: 2]),
      .in_pin         (in_pins[i]),
      .fault          (faults[i]),
      .drive_on       (channel_on[i]),
      .fault_flag     (fault_flags[i]),
      .open_load_flag (open_flags[i])
    );
    assign diag_word[2*i+1] = open_flags[i];
    assign diag_word[2*i]   = fault_flags[i];
  end

  // ---------------------------------------------------------------
  // Edge detection on synchronised pins
  // ---------------------------------------------------------------
  // Edges on the clock line count only while selected, so a
  // deselected bus never disturbs the shifter.
  assign cs_fall   = state.cs_n_d && !pins.cs_n;
  assign cs_rise   = !state.cs_n_d && pins.cs_n;
  assign sclk_rise = !state.sclk_d && pins.sclk && state.active && !pins.cs_n;
  assign sclk_fall = state.sclk_d && !pins.sclk && state.active && !pins.cs_n;

  // ---------------------------------------------------------------
  // Serial engine
  // ---------------------------------------------------------------
  always_comb begin
    next_state        = state;
    next_state.sclk_d = pins.sclk;
    next_state.cs_n_d = pins.cs_n;
    if (cs_fall) begin
      next_state.active          = 1'b1;
      next_state.tx_shift        = diag_word;
      next_state.bit_count       = '0;
      next_state.first_rise_seen = 1'b0;
      next_state.miso            = state.error_flag;
    end else if (cs_rise) begin
      next_state.active = 1'b0;
      if (state.active && count_valid(state.bit_count)) begin
        next_state.command    = state.rx_shift;
        next_state.error_flag = 1'b0;
      end else begin
        next_state.error_flag = 1'b1;
      end
    end else begin
      if (sclk_fall) begin
        next_state.rx_shift  = {state.rx_shift[14:0], pins.mosi};
        if (state.bit_count != '1) begin
          next_state.bit_count = state.bit_count + 1'b1;
        end
      end
      if (sclk_rise) begin
        // Leaving the error indication: first data bit goes out.
        next_state.first_rise_seen = 1'b1;
        next_state.miso            = state.tx_shift[15];
        next_state.tx_shift        = {state.tx_shift[14:0], state.rx_shift[15]};
      end
    end
    if (srst) begin
      next_state            = '0;
      next_state.command    = relay_diag_pkg::CMD_RESET;
      next_state.error_flag = 1'b1;
      next_state.sclk_d     = 1'b0;
      next_state.cs_n_d     = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Before the first clock rise the output is the error flag OR the
  // live input, so a chain upstream can pass its own error forward.
  // The input term is combinational on purpose for that reason.
  always_comb begin
    miso_oe  = state.active;
    miso_out = state.first_rise_seen ? state.miso : (state.miso | pins.mosi);
    if (!state.active) begin
      miso_out = 1'b0;
    end
  end

  assign command_word        = state.command;
  assign transfer_error_flag = state.error_flag;

  chk_reset_defaults: assert property (@(posedge clk)
    srst |=> state.command == 16'hFFFF && state.error_flag && !miso_oe)
    else $error("reset defaults wrong");
  chk_idle_released: assert property (@(posedge clk) disable iff (srst)
    !state.active |-> !miso_oe)
    else $error("output driven while deselected");
  chk_load_diag: assert property (@(posedge clk) disable iff (srst)
    cs_fall |=> state.tx_shift == $past(diag_word) && state.bit_count == '0)
    else $error("select fall did not load flags");
  chk_error_shown: assert property (@(posedge clk) disable iff (srst)
    cs_fall ##1 (!sclk_rise && !cs_rise && !cs_fall) |-> miso_oe && (miso_out == (state.error_flag | pins.mosi)))
    else $error("error indication not driven");
  chk_bad_count: assert property (@(posedge clk) disable iff (srst)
    cs_rise && !count_valid(state.bit_count) |=> state.error_flag && $stable(state.command))
    else $error("invalid frame accepted");
  chk_good_count: assert property (@(posedge clk) disable iff (srst)
    cs_rise && state.active && count_valid(state.bit_count) |=> !state.error_flag
      && state.command == $past(state.rx_shift))
    else $error("valid frame not taken");
  chk_count_step: assert property (@(posedge clk) disable iff (srst)
    sclk_fall && !cs_rise && !cs_fall && state.bit_count < 8'h10 |=> state.bit_count == $past(state.bit_count) + 8'h01)
    else $error("bit counter did not step");
  chk_msb_first: assert property (@(posedge clk) disable iff (srst)
    sclk_rise && !cs_rise && !cs_fall |=> state.miso == $past(state.tx_shift[15]))
    else $error("output not most significant first");

endmodule

// *** verification/spi_master_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Serial master on the far side
// ----------------------------------------
// The clock rests low outside frames. The data line flips when released, so a stale bit never looks valid.
module spi_master_model (
  input  wire logic clk,
  input  wire logic miso_out,
  input  wire logic miso_oe,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic xfer(input int n, input logic [31:0] tx, input logic si0, output logic [31:0] rx,
                      output logic err);
    rx = 32'h0;
    @(posedge clk);
    #1;
    mosi = si0;
    cs_n = 1'b0;
    #125;
    err = miso_oe ? miso_out : 1'bx;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      #31.25;
      mosi = tx[i];
      #31.25;
      sclk = 1'b0;
      rx[i] = miso_oe ? miso_out : 1'bx;
      #62.5;
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    #125;
  endtask
endmodule

// *** verification/relay_switch_spi_diagnosis_bench.sv ***
`timescale 1ns/100ps
module relay_switch_spi_diagnosis_bench;
  logic                      clk;
  logic                      srst;
  logic                      sclk;
  logic                      cs_n;
  logic                      mosi;
  logic                      miso_out;
  logic                      miso_oe;
  logic [7:0]                in_pins;
  relay_diag_pkg::fault_in_t faults [8];
  logic [7:0]                channel_on;
  logic [15:0]               command_word;
  logic                      transfer_error_flag;
  int                        bad_count;
  int                        comparisons;
  logic [31:0]               rx;
  logic                      err;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  relay_switch_spi_diagnosis u_dut (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso_out(miso_out), .miso_oe(miso_oe), .in_pins(in_pins), .faults(faults), .channel_on(channel_on),
    .command_word(command_word), .transfer_error_flag(transfer_error_flag));

  spi_master_model u_master (.clk(clk), .miso_out(miso_out), .miso_oe(miso_oe), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic frame(input int n, input logic [31:0] tx, input logic si0, input logic exp_err,
                       input logic [15:0] exp_rx);
    int k;
    u_master.xfer(n, tx, si0, rx, err);
    chk(err, exp_err);
    if (n == 16)
      chk(rx[15:0], exp_rx);
    k = 0;
    while (miso_oe !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk(miso_oe, 1'b0);
    if (miso_oe !== 1'b0)
      tally_and_finish();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset_state();
    chk(command_word, 16'hFFFF);
    chk(transfer_error_flag, 1'b1);
    chk(channel_on, 8'h00);
  endtask

  task automatic test_first_frame();
    frame(16, 32'h34AB, 1'b0, 1'b1, 16'h0000);
    chk(command_word, 16'h34AB);
    chk(transfer_error_flag, 1'b0);
    frame(16, 32'h34AB, 1'b1, 1'b1, 16'h0000);
    frame(16, 32'h34AB, 1'b0, 1'b0, 16'h0000);
  endtask

  task automatic test_bad_counts();
    int bad_n [3];
    bad_n = '{8, 12, 17};
    foreach (bad_n[i]) begin
      frame(bad_n[i], 32'h1FFFF, 1'b0, i != 0, 16'h0000);
      chk(command_word, 16'h34AB);
      chk(transfer_error_flag, 1'b1);
    end
    // A chained frame keeps only the last word, so the leading byte must not land.
    frame(24, 32'h5534AB, 1'b0, 1'b1, 16'h0000);
    chk(command_word, 16'h34AB);
    chk(transfer_error_flag, 1'b0);
  endtask

  task automatic test_input_mode();
    @(posedge clk);
    in_pins <= 8'h20;
    cyc(2);
    chk(channel_on, 8'h2E);
    in_pins <= 8'hDF;
    cyc(2);
    chk(channel_on, 8'h0E);
  endtask

  task automatic test_protection();
    @(posedge clk);
    faults[0].open_load <= 1'b1;
    faults[1].overload <= 1'b1;
    faults[2].overtemp <= 1'b1;
    faults[3].open_load <= 1'b1;
    faults[4].open_load <= 1'b1;
    cyc(250);
    chk(channel_on, 8'h0A);
    cyc(100);
    chk(channel_on, 8'h08);
    faults[1].overload <= 1'b0;
    faults[2].overtemp <= 1'b0;
    cyc(2000);
    frame(16, 32'h34AB, 1'b0, 1'b0, 16'h0014);
    cyc(1000);
    frame(16, 32'h34AB, 1'b0, 1'b0, 16'h0016);
    chk(channel_on, 8'h08);
  endtask

  task automatic test_standby_clear();
    frame(16, 32'h3480, 1'b0, 1'b0, 16'h0016);
    chk(command_word, 16'h3480);
    cyc(3200);
    frame(16, 32'h34AB, 1'b0, 1'b0, 16'h0000);
    chk(channel_on, 8'h0E);
  endtask

  task automatic test_second_reset();
    @(posedge clk);
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    cyc(4);
    chk(command_word, 16'hFFFF);
    frame(16, 32'hFFFF, 1'b0, 1'b1, 16'h0000);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    bad_count = 0;
    comparisons = 0;
    srst = 1'b1;
    in_pins = 8'h00;
    foreach (faults[i])
      faults[i] = '0;
    cyc(3);
    srst <= 1'b0;
    cyc(4);
    test_reset_state();
    test_first_frame();
    test_bad_counts();
    test_input_mode();
    test_protection();
    test_standby_clear();
    test_second_reset();
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
